// >>> core/hlf_consts.vh
// Functional notes
// - Down/up states; packet mode adds mid-message state
// - Answer every received hello with a control frame
// - Looped hello returned unchanged, no other answer
// - Looped data frame returned, still processed normally
// - Host-originated frames are errors and dropped
// - Each hello reloads timer from line-down count
// - Message mode down: level up flag raises level
// - Message mode down: sequence break flushes if up
// - Level down: data frames not processed
// - Message mode up: level flag clear drops level
// - Message mode up: only single-frame messages processed
// - Packet mode down: level up flag goes awaiting-first
// - Packet mode down: break flushes only with level up
// - Awaiting first: level flag clear drops level
// - Awaiting first: sequence break ignored
// - Awaiting first: fragment flags decide accept/discard/single
// - Mid-message: break discards partial, first flag restarts
// - Mid-message: level flag clear drops, discards partial
// - Mid-message: first fragment flag restarts message
// - Mid-message: last fragment completes, back to awaiting
// - Mid-message: no fragment flags is middle fragment
// - Header bit layout, 10-bit line-down count low
// - Timer counts seconds while up, expiry drops level; a data frame that changes state in the expiry cycle keeps it up
// - Answer clears originator, level up only if hello had it
//
// Purpose: constants of the host link frame state machine
// Assumes: included by core/hlf_frame_fsm.v only
// Notes: header bits count from bit 0 at the right
`ifndef HLF_CONSTS_VH
`define HLF_CONSTS_VH

`define HLF_B_CTL 15
`define HLF_B_BRK 14
`define HLF_B_ORIG 13
`define HLF_B_LVL 12
`define HLF_B_POOR 11
`define HLF_B_LOOP 10
`define HLF_CNT_HI 9
`define HLF_CNT_W 10
`define HLF_B_FIRST 1
`define HLF_B_LAST 0

`define HLF_TMR_ZERO 10'h000
`define HLF_TMR_LAST 10'h001

`define HLF_S_ST_HI 1
`define HLF_S_ST_LO 0
`define HLF_S_UP 2
`define HLF_S_POOR 3
`define HLF_S_TMR_HI 25
`define HLF_S_TMR_LO 16

`define HLF_ST_DOWN 2'h0
`define HLF_ST_UP 2'h1
`define HLF_ST_MID 2'h2

`define HLF_A_CTRL 12'h000
`define HLF_A_PRESC 12'h004
`define HLF_A_STAT 12'h008
`define HLF_A_ERRS 12'h00C
`define HLF_CTRL_PKT 0
`define HLF_CTRL_ALLOW 1
`define HLF_CTRL_RST 2'h2
`define HLF_CTRL_HI 1

`define HLF_CLK_HZ 100000000
`define HLF_TICK_S 1

`endif

// >>> core/hlf_frame_fsm.v
// Purpose: host receive state machine for the framed host/switch link
// Assumes: one header per frame, payload handled by the caller
// Notes: APB slave, zero wait states
// Notes: decisions are made combinationally and shown one cycle later
// Notes: only one outgoing frame is held, so intake waits for it
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "hlf_consts.vh"

module hlf_frame_fsm #(
    parameter [31:0] TICK_CYCLES = `HLF_TICK_S * `HLF_CLK_HZ
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rx_valid,
    input wire [15:0] rx_hdr,
    output wire rx_ready,
    output reg tx_valid,
    output reg [15:0] tx_hdr,
    output reg tx_loop,
    input wire tx_ready,
    output wire link_up,
    output reg link_poor,
    output wire data_take,
    output wire msg_done,
    output wire msg_drop,
    output wire frame_drop,
    output wire queue_flush,
    output wire hdr_error
);

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`HLF_CNT_W-1:0] timer_r;
    reg [`HLF_CNT_W-1:0] timer_nxt;
    reg [31:0] presc_r;
    reg [31:0] tick_cnt_r;
    reg [1:0] ctrl_r;
    reg [15:0] err_cnt_r;
    reg tick;
    reg take_n, done_n, mdrop_n, fdrop_n, flush_n, err_n;
    reg send_n, loop_n;
    reg [15:0] send_hdr_n;

    wire rx_fire = rx_valid & rx_ready;
    wire is_ctl = rx_hdr[`HLF_B_CTL];
    wire seq_brk = rx_hdr[`HLF_B_BRK];
    wire from_imp = rx_hdr[`HLF_B_ORIG];
    wire lvl = rx_hdr[`HLF_B_LVL];
    wire poor = rx_hdr[`HLF_B_POOR];
    wire loop_req = rx_hdr[`HLF_B_LOOP];
    wire pkt_mode = ctrl_r[`HLF_CTRL_PKT];
    wire expire = tick && (state_r != `HLF_ST_DOWN) && (timer_r <= `HLF_TMR_LAST);

    // Data frame fragment flags ride in the line-down count field bits
    wire first_fragment_flag = rx_hdr[`HLF_B_FIRST];
    wire last_fragment_flag = rx_hdr[`HLF_B_LAST];

    // Frame classes taken at this edge; host-origin frames go nowhere else
    wire bad_fire = rx_fire & ~from_imp;
    wire ctl_fire = rx_fire & from_imp & is_ctl;
    wire data_fire = rx_fire & from_imp & ~is_ctl;

    // Only one outgoing frame can be pending, so intake stalls behind it
    assign rx_ready = ~tx_valid;

    // One-second tick from the programmable prescaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (tick_cnt_r + 32'h1 >= presc_r) begin
            tick_cnt_r <= 32'h0;
            tick <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end

    always @* begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        take_n = 1'b0;
        done_n = 1'b0;
        mdrop_n = 1'b0;
        fdrop_n = 1'b0;
        flush_n = 1'b0;
        err_n = 1'b0;
        send_n = 1'b0;
        loop_n = 1'b0;
        send_hdr_n = rx_hdr;
        if (tick && state_r != `HLF_ST_DOWN && timer_r != `HLF_TMR_ZERO)
            timer_nxt = timer_r - 1'b1;
        if (expire) begin
            if (state_r == `HLF_ST_MID)
                mdrop_n = 1'b1;
            state_nxt = `HLF_ST_DOWN;
        end
        if (bad_fire) begin
            err_n = 1'b1;
            fdrop_n = 1'b1;
        end else if (ctl_fire) begin
            // A hello in the expiry cycle reloads the timer, so it wins
            state_nxt = state_r;
            mdrop_n = 1'b0;
            timer_nxt = rx_hdr[`HLF_CNT_HI:0];
            send_n = 1'b1;
            if (loop_req) begin
                loop_n = 1'b1;
            end else begin
                send_hdr_n[`HLF_B_ORIG] = 1'b0;
                send_hdr_n[`HLF_B_LVL] = lvl & ctrl_r[`HLF_CTRL_ALLOW];
            end
            case (state_r)
                `HLF_ST_DOWN: begin
                    if (lvl) begin
                        state_nxt = `HLF_ST_UP;
                        flush_n = seq_brk;
                    end
                end
                `HLF_ST_UP: begin
                    if (!lvl)
                        state_nxt = `HLF_ST_DOWN;
                    // Sequence break has nothing to discard here
                end
                `HLF_ST_MID: begin
                    if (!lvl) begin
                        state_nxt = `HLF_ST_DOWN;
                        mdrop_n = 1'b1;
                    end else if (seq_brk) begin
                        state_nxt = `HLF_ST_UP;
                        mdrop_n = 1'b1;
                    end
                end
                default: state_nxt = `HLF_ST_DOWN;
            endcase
        end else if (data_fire) begin
            if (loop_req) begin
                send_n = 1'b1;
                loop_n = 1'b1;
            end
            case (state_r)
                `HLF_ST_DOWN: begin
                    fdrop_n = 1'b1;
                end
                `HLF_ST_UP: begin
                    if (first_fragment_flag && last_fragment_flag) begin
                        take_n = 1'b1;
                        done_n = 1'b1;
                    end else if (pkt_mode && first_fragment_flag) begin
                        take_n = 1'b1;
                        state_nxt = `HLF_ST_MID;
                    end else begin
                        fdrop_n = 1'b1;
                    end
                end
                `HLF_ST_MID: begin
                    if (first_fragment_flag) begin
                        mdrop_n = 1'b1;
                        take_n = 1'b1;
                        if (last_fragment_flag) begin
                            done_n = 1'b1;
                            state_nxt = `HLF_ST_UP;
                        end
                    end else if (seq_brk) begin
                        mdrop_n = 1'b1;
                        fdrop_n = 1'b1;
                        state_nxt = `HLF_ST_UP;
                    end else if (last_fragment_flag) begin
                        take_n = 1'b1;
                        done_n = 1'b1;
                        state_nxt = `HLF_ST_UP;
                    end else begin
                        take_n = 1'b1;
                    end
                end
                default: state_nxt = `HLF_ST_DOWN;
            endcase
        end
        // A mode change to message mode abandons any partial message
        if (!pkt_mode && state_nxt == `HLF_ST_MID)
            state_nxt = `HLF_ST_UP;
    end

    // Reset leaves the link down and the timer stopped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= `HLF_ST_DOWN;
            timer_r <= `HLF_TMR_ZERO;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
        end
    end

    // Quality-poor bit follows the latest hello from the switch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_poor <= 1'b0;
        end else if (ctl_fire) begin
            link_poor <= poor;
        end
    end

    // One outgoing frame register; a new send overrides the ready drain
    // Intake is refused meanwhile, so no answer is ever lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_hdr <= 16'h0000;
            tx_loop <= 1'b0;
        end else if (send_n) begin
            tx_valid <= 1'b1;
            tx_hdr <= send_hdr_n;
            tx_loop <= loop_n;
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // Decision pulses are registered copies of the decode above
    wire up_nxt = (state_nxt != `HLF_ST_DOWN);

    hlf_pulse_reg #(
        .W(1)
    ) i_up (
        .pclk(pclk),
        .presetn(presetn),
        .d(up_nxt),
        .q(link_up)
    );

    hlf_pulse_reg #(
        .W(1)
    ) i_take (
        .pclk(pclk),
        .presetn(presetn),
        .d(take_n),
        .q(data_take)
    );

    hlf_pulse_reg #(
        .W(1)
    ) i_done (
        .pclk(pclk),
        .presetn(presetn),
        .d(done_n),
        .q(msg_done)
    );

    hlf_pulse_reg #(
        .W(1)
    ) i_mdrop (
        .pclk(pclk),
        .presetn(presetn),
        .d(mdrop_n),
        .q(msg_drop)
    );

    hlf_pulse_reg #(
        .W(1)
    ) i_fdrop (
        .pclk(pclk),
        .presetn(presetn),
        .d(fdrop_n),
        .q(frame_drop)
    );

    hlf_pulse_reg #(
        .W(1)
    ) i_flush (
        .pclk(pclk),
        .presetn(presetn),
        .d(flush_n),
        .q(queue_flush)
    );

    hlf_pulse_reg #(
        .W(1)
    ) i_err (
        .pclk(pclk),
        .presetn(presetn),
        .d(err_n),
        .q(hdr_error)
    );

    // APB slave, always ready
    // Unmapped offsets read zero and flag pslverr
    wire wr = psel & penable & pwrite;
    wire sel_ctrl = (paddr == `HLF_A_CTRL);
    wire sel_presc = (paddr == `HLF_A_PRESC);
    wire sel_stat = (paddr == `HLF_A_STAT);
    wire sel_errs = (paddr == `HLF_A_ERRS);
    wire hit = sel_ctrl | sel_presc | sel_stat | sel_errs;
    wire wr_ctrl = wr & sel_ctrl;
    wire wr_presc = wr & sel_presc;
    wire wr_errs = wr & sel_errs;
    // A zero period is stored as one; either value gives a tick every cycle
    wire [31:0] presc_wr = (pwdata == 32'h0) ? 32'h1 : pwdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `HLF_CTRL_RST;
            presc_r <= TICK_CYCLES;
            err_cnt_r <= 16'h0000;
        end else begin
            if (wr_ctrl)
                ctrl_r <= pwdata[`HLF_CTRL_HI:0];
            if (wr_presc)
                presc_r <= presc_wr;
            // A new error in the clearing cycle still counts
            if (err_n)
                err_cnt_r <= wr_errs ? 16'h0001 : err_cnt_r + 16'h1;
            else if (wr_errs)
                err_cnt_r <= 16'h0000;
        end
    end

    // Status fields packed by name so the layout lives in the header
    reg [31:0] stat_word;
    always @* begin
        stat_word = 32'h0000_0000;
        stat_word[`HLF_S_ST_HI:`HLF_S_ST_LO] = state_r;
        stat_word[`HLF_S_UP] = link_up;
        stat_word[`HLF_S_POOR] = link_poor;
        stat_word[`HLF_S_TMR_HI:`HLF_S_TMR_LO] = timer_r;
    end

    always @* begin
        case (paddr)
            `HLF_A_CTRL: prdata = {30'h0, ctrl_r};
            `HLF_A_PRESC: prdata = presc_r;
            `HLF_A_STAT: prdata = stat_word;
            `HLF_A_ERRS: prdata = {16'h0, err_cnt_r};
            default: prdata = 32'h0;
        endcase
    end

endmodule // hlf_frame_fsm

// Registered copy of a one-cycle decision, cleared by reset
// W lets a group of pulses share one instance if wanted
module hlf_pulse_reg #(
    parameter W = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= {W{1'b0}};
        end else begin
            q <= d;
        end
    end

endmodule // hlf_pulse_reg

// >>> dv/hlf_frame_fsm_chk.sv
// Purpose: port assertions for hlf_frame_fsm
// Assumes: results show one cycle after a taken frame
// Notes: a frame counts only at an edge with rx_valid and rx_ready
`timescale 1ns/1ps
module hlf_frame_fsm_chk (
    input wire pclk,
    input wire presetn,
    input wire rx_valid,
    input wire [15:0] rx_hdr,
    input wire rx_ready,
    input wire tx_valid,
    input wire [15:0] tx_hdr,
    input wire tx_loop,
    input wire tx_ready,
    input wire link_up,
    input wire msg_done,
    input wire queue_flush,
    input wire hdr_error
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ok = rx_valid && rx_ready && rx_hdr[13];
    wire hello = ok && rx_hdr[15] && !rx_hdr[10];
    sequence answer_s;
        tx_valid && !tx_loop && tx_hdr[15:13] == {$past(rx_hdr[15:14]), 1'b0};
    endsequence
    sequence held_s;
        tx_valid && $stable(tx_hdr);
    endsequence
    origin_drop_a: assert property (rx_valid && rx_ready && !rx_hdr[13] |=> hdr_error && !tx_valid)
        else $error("host-origin frame not dropped");
    answer_a: assert property (hello |=> answer_s ##0 tx_hdr[9:0] == $past(rx_hdr[9:0]))
        else $error("hello answer wrong");
    level_bit_a: assert property (hello |=> !tx_hdr[12] || $past(rx_hdr[12]))
        else $error("answer raised level without hello");
    loop_a: assert property (ok && rx_hdr[10] |=> tx_valid && tx_loop && tx_hdr == $past(rx_hdr))
        else $error("loopback frame wrong");
    hold_a: assert property (tx_valid && !tx_ready |=> held_s)
        else $error("pending frame dropped");
    up_a: assert property (hello && rx_hdr[12] |=> link_up)
        else $error("level not raised");
    down_a: assert property (ok && rx_hdr[15] && !rx_hdr[12] |=> !link_up)
        else $error("level not dropped");
    flush_a: assert property (ok && rx_hdr[15:14] == 2'h3 && rx_hdr[12] && !link_up |=> queue_flush)
        else $error("queues not flushed");
    noflush_a: assert property (ok && rx_hdr[15] && !rx_hdr[12] |=> !queue_flush)
        else $error("flush without level up");
    quiet_a: assert property (ok && !rx_hdr[15] && !link_up |=> !msg_done)
        else $error("data used while down");
endmodule // hlf_frame_fsm_chk

// >>> dv/hlf_frame_fsm_tb_top.sv
// Purpose: bench for hlf_frame_fsm
// Assumes: APB master waits for pready, results one cycle after a taken frame
// Notes: prescaler set to 10 so timer expiry fits the run
`timescale 1ns/1ps
module hlf_frame_fsm_tb_top;
    reg pclk, presetn, psel, penable, pwrite, err;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire pready, pslverr, rx_valid, rx_ready, tx_valid, tx_loop, tx_ready, link_up, link_poor;
    wire data_take, msg_done, msg_drop, frame_drop, queue_flush, hdr_error;
    wire [15:0] rx_hdr, tx_hdr;
    integer n_errors = 0, checks_done = 0, cyc = 0, i;
    reg [22:0] rows [0:19];
    hlf_frame_fsm i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_valid, .rx_hdr, .rx_ready, .tx_valid, .tx_hdr, .tx_loop,
        .tx_ready, .link_up, .link_poor, .data_take, .msg_done, .msg_drop, .frame_drop,
        .queue_flush, .hdr_error);
    hlf_imp_model i_imp (.pclk, .rx_ready, .rx_valid, .rx_hdr, .tx_ready);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (!pready) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
        rows[0] = {1'b1, 16'h2003, 6'h04};
        rows[1] = {1'b1, 16'hF005, 6'h23};
        rows[2] = {1'b1, 16'h2001, 6'h24};
        rows[3] = {1'b1, 16'h2003, 6'h30};
        rows[4] = {1'b1, 16'h2002, 6'h20};
        rows[5] = {1'b1, 16'h2000, 6'h20};
        rows[6] = {1'b1, 16'h2002, 6'h28};
        rows[7] = {1'b1, 16'hF005, 6'h29};
        rows[8] = {1'b1, 16'h6001, 6'h24};
        rows[9] = {1'b1, 16'h2002, 6'h20};
        rows[10] = {1'b1, 16'h2001, 6'h30};
        rows[11] = {1'b1, 16'h2002, 6'h20};
        rows[12] = {1'b1, 16'hA005, 6'h09};
        rows[13] = {1'b1, 16'hB005, 6'h21};
        rows[14] = {1'b0, 16'h2002, 6'h24};
        rows[15] = {1'b0, 16'h2003, 6'h30};
        rows[16] = {1'b0, 16'hA005, 6'h01};
        rows[17] = {1'b0, 16'hF405, 6'h23};
        rows[18] = {1'b0, 16'h2403, 6'h31};
        rows[19] = {1'b0, 16'h8005, 6'h24};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h004, 32'hA);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'hA);
        for (i = 0; i < 20; i = i + 1) begin
            if (i == 0 || rows[i][22] != rows[i - 1][22]) apb(1'b1, 12'h000, {30'h0, 1'b1, rows[i][22]});
            i_imp.send(rows[i][21:6]);
            #1;
            chk({link_up, msg_done, msg_drop, frame_drop, queue_flush, tx_valid}, rows[i][5:0]);
        end
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h0);
        // Stalled answer must wait, then a 3 s timer must expire
        i_imp.set_ready(1'b0);
        i_imp.send(16'hB003);
        repeat (3) @(posedge pclk);
        #1;
        chk(tx_valid, 1'b1);
        i_imp.set_ready(1'b1);
        repeat (9) @(posedge pclk);
        #1;
        chk(link_up, 1'b1);
        repeat (22) @(posedge pclk);
        #1;
        chk(link_up, 1'b0);
        test_done;
    end
endmodule // hlf_frame_fsm_tb_top
bind hlf_frame_fsm hlf_frame_fsm_chk i_chk (.pclk, .presetn, .rx_valid, .rx_hdr, .rx_ready,
    .tx_valid, .tx_hdr, .tx_loop, .tx_ready, .link_up, .msg_done, .queue_flush, .hdr_error);

// >>> dv/hlf_imp_model.sv
// Purpose: switching node side, offers headers and takes answers
// Assumes: rx_ready is sampled at the rising edge that takes the header
// Notes: a released header is inverted so a stale value never matches
`timescale 1ns/1ps
module hlf_imp_model (
    input wire pclk,
    input wire rx_ready,
    output reg rx_valid,
    output reg [15:0] rx_hdr,
    output reg tx_ready
);
    initial begin
        rx_valid = 1'b0;
        rx_hdr = 16'h0000;
        tx_ready = 1'b1;
    end
    // Caller composes headers in the frame layout
    task send(input [15:0] h);
        begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_hdr <= h;
            @(posedge pclk);
            while (!rx_ready) @(posedge pclk);
            rx_valid <= 1'b0;
            rx_hdr <= ~h;
        end
    endtask
    task set_ready(input r);
        begin
            tx_ready <= r;
        end
    endtask
endmodule // hlf_imp_model
